//--- design/timer_capture_pkg.sv
package timer_capture_pkg;

  // ***************************************************************
  // register map, byte addresses on the bus
  // ***************************************************************
  localparam logic [11:0] OFF_MAIN_CONTROL = 12'h000;
  localparam logic [11:0] OFF_TIMER_STATUS = 12'h004;
  localparam logic [11:0] OFF_EVENT_GENERATE = 12'h008;
  localparam logic [11:0] OFF_EXT_CLOCK = 12'h00C;
  localparam logic [11:0] OFF_CHANNEL_CONFIG = 12'h010;
  localparam logic [11:0] OFF_COUNTER_VALUE = 12'h014;
  localparam logic [11:0] OFF_PRESCALER_VALUE = 12'h018;
  localparam logic [11:0] OFF_AUTO_RELOAD = 12'h01C;
  localparam logic [11:0] OFF_COMPARE_VALUE = 12'h020;
  localparam logic [11:0] OFF_CH2_CAPTURE = 12'h024;
  localparam logic [11:0] OFF_REPETITION = 12'h028;

  // ***************************************************************
  // field layouts, low bit of each struct is bit 0 of its word
  // ***************************************************************
  typedef struct packed {
    logic single_shot_bit;
    logic update_suppress;
    logic counter_run_enable;
  } main_control_t;

  typedef struct packed {
    logic ch2_overcapture_flag;
    logic ch2_capture_flag;
    logic update_flag;
  } timer_status_t;

  typedef struct packed {
    logic etr_invert;
    logic [1:0] etr_prescale;
    logic ext_clock_mode2_enable;
  } ext_clock_t;

  typedef struct packed {
    logic ch1_out_enable;
    logic ch1_invert;
    logic [2:0] ch1_mode;
    logic ch2_dma_enable;
    logic ch2_capture_enable;
    logic ch2_falling;
    logic [1:0] ch2_input_select;
  } channel_config_t;

  localparam int UPDATE_GENERATE_BIT = 0;

  // ***************************************************************
  // encodings and reset values
  // ***************************************************************
  localparam logic [1:0] CH2_SELECT_DIRECT = 2'h1;
  localparam logic [2:0] OC_PWM_MODE_FIRST = 3'h6;
  localparam logic [2:0] OC_PWM_MODE_SECOND = 3'h7;
  localparam logic [1:0] ETR_DIV4 = 2'h2;
  localparam main_control_t MAIN_CONTROL_RESET = 3'h0;
  localparam timer_status_t TIMER_STATUS_RESET = 3'h0;
  localparam ext_clock_t EXT_CLOCK_RESET = 4'h0;
  localparam channel_config_t CHANNEL_CONFIG_RESET = 10'h000;
  localparam logic [31:0] AUTO_RELOAD_RESET = 32'hFFFFFFFF;

endpackage

//--- design/timer_capture_onepulse.sv
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
// Contract
// - each active ch2 edge copies the counter into the capture register
// - each ch2 capture sets the capture flag
// - with dma enable set, each ch2 capture raises a dma request
// - capture while capture flag still set also sets overcapture flag
// - rising input transition can be chosen as the active edge
// - input select at direct value routes ch2 input to capture path
// - counter is 32 bits and counts upward to the auto-reload value
// - ext clock mode 2 enable makes trigger edges advance the counter
// - trigger path has divide-by-4 prescaler and rising-edge polarity
// - update generate reloads prescaler and preloaded values at once
// - single shot plus unmasked update clears run enable, holds counter
// - up-counting single-shot stop leaves the counter at 0
// - masked update keeps run enable set and outputs running
// - update suppress masks update effects, single-shot stop included
// - nonzero repetition counter masks the update effect
// - repetition-masked update decrements repetition; update at zero reloads it, and stops in single shot
// - single shot works with either pwm output mode
// - second pwm mode gives delay then pulse; invert or first flips it
// - delay equals compare value, pulse is reload minus compare plus 1
module timer_capture_onepulse
  import timer_capture_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int PSC_W = 16,
  parameter int REP_W = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external signals
  input wire logic ch2_in,
  input wire logic external_trigger_input,
  // outputs
  output logic ch1_out,
  output logic ch2_dma_req
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

  // set beats clear, so no event is lost in the clearing cycle
  function automatic logic sticky(input logic flag, input logic set,
                                  input logic clr);
    return set | (flag & ~clr);
  endfunction

  localparam logic [CNT_W-1:0] CNT_ONE = 1;
  localparam logic [PSC_W-1:0] PSC_ONE = 1;
  localparam logic [REP_W-1:0] REP_ONE = 1;

  main_control_t ctrl;
  timer_status_t status;
  ext_clock_t ext_cfg;
  channel_config_t chan_cfg;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] auto_reload_value;
  logic [CNT_W-1:0] ch2_capture_compare_value;
  logic [CNT_W-1:0] channel_compare_value;
  logic [PSC_W-1:0] prescaler_value;
  logic [PSC_W-1:0] psc_active;
  logic [PSC_W-1:0] psc_cnt;
  logic [REP_W-1:0] repetition_count;
  logic [REP_W-1:0] rep_cnt;
  logic [2:0] etr_div_cnt;
  logic etr_prev;
  logic ch2_prev;

  // ***************************************************************
  // bus decode
  // ***************************************************************
  logic access;
  logic wr;
  logic wr_main;
  logic wr_status;
  logic rd_capture;
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign wr_main = wr & hit(paddr, OFF_MAIN_CONTROL);
  assign wr_status = wr & hit(paddr, OFF_TIMER_STATUS);
  assign rd_capture = access & ~pwrite & hit(paddr, OFF_CH2_CAPTURE);

  // ***************************************************************
  // time base
  // ***************************************************************
  logic etr_level;
  logic etr_tick;
  logic [2:0] etr_div_max;
  logic src_tick;
  logic cnt_tick;
  logic overflow;
  logic ug;
  logic upd_event;
  logic rep_masked;
  logic stop;

  assign etr_level = external_trigger_input ^ ext_cfg.etr_invert;
  assign etr_div_max = 3'((4'h1 << ext_cfg.etr_prescale) - 4'h1);
  assign etr_tick = etr_level & ~etr_prev & (etr_div_cnt == etr_div_max);
  assign src_tick = ext_cfg.ext_clock_mode2_enable ? etr_tick : 1'b1;
  assign cnt_tick = ctrl.counter_run_enable & src_tick
                    & (psc_cnt == psc_active);
  assign overflow = cnt_tick & (counter == auto_reload_value);
  assign ug = wr & hit(paddr, OFF_EVENT_GENERATE)
              & pwdata[UPDATE_GENERATE_BIT];
  // repetition and suppress both mask the update effect
  assign rep_masked = overflow & ~ctrl.update_suppress
                      & (rep_cnt != '0);
  assign upd_event = ug | (overflow & ~ctrl.update_suppress
                           & (rep_cnt == '0));
  assign stop = overflow & ctrl.single_shot_bit & ~ctrl.update_suppress
                & (rep_cnt == '0);

  // edge divider on the trigger input; edges only, one per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      etr_prev <= 1'b0;
      etr_div_cnt <= 3'h0;
    end else begin
      etr_prev <= etr_level;
      if (etr_level & ~etr_prev) begin
        etr_div_cnt <= (etr_div_cnt == etr_div_max) ? 3'h0
                       : etr_div_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_cnt <= '0;
      psc_active <= '0;
    end else begin
      if (upd_event) begin
        psc_active <= prescaler_value;
      end
      if (ug) begin
        psc_cnt <= '0;
      end else if (ctrl.counter_run_enable & src_tick) begin
        psc_cnt <= (psc_cnt == psc_active) ? '0 : psc_cnt + PSC_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= '0;
    end else if (ug) begin
      counter <= '0;
    end else if (wr & hit(paddr, OFF_COUNTER_VALUE)) begin
      counter <= pwdata[CNT_W-1:0];
    end else if (cnt_tick) begin
      // wraps to zero, where a single-shot stop leaves it
      counter <= overflow ? '0 : counter + CNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_cnt <= '0;
    end else if (upd_event) begin
      rep_cnt <= repetition_count;
    end else if (rep_masked) begin
      rep_cnt <= rep_cnt - REP_ONE;
    end
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= MAIN_CONTROL_RESET;
    end else if (wr_main) begin
      ctrl <= main_control_t'(pwdata[2:0]);
    end else if (stop) begin
      ctrl.counter_run_enable <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cfg <= EXT_CLOCK_RESET;
      chan_cfg <= CHANNEL_CONFIG_RESET;
      auto_reload_value <= AUTO_RELOAD_RESET[CNT_W-1:0];
      channel_compare_value <= '0;
      prescaler_value <= '0;
      repetition_count <= '0;
    end else if (wr) begin
      if (hit(paddr, OFF_EXT_CLOCK)) begin
        ext_cfg <= ext_clock_t'(pwdata[3:0]);
      end
      if (hit(paddr, OFF_CHANNEL_CONFIG)) begin
        chan_cfg <= channel_config_t'(pwdata[9:0]);
      end
      if (hit(paddr, OFF_AUTO_RELOAD)) begin
        auto_reload_value <= pwdata[CNT_W-1:0];
      end
      if (hit(paddr, OFF_COMPARE_VALUE)) begin
        channel_compare_value <= pwdata[CNT_W-1:0];
      end
      if (hit(paddr, OFF_PRESCALER_VALUE)) begin
        prescaler_value <= pwdata[PSC_W-1:0];
      end
      if (hit(paddr, OFF_REPETITION)) begin
        repetition_count <= pwdata[REP_W-1:0];
      end
    end
  end

  // ***************************************************************
  // channel 2 capture
  // ***************************************************************
  logic cap_en;
  logic ch2_edge;
  assign cap_en = chan_cfg.ch2_capture_enable
                  & (chan_cfg.ch2_input_select == CH2_SELECT_DIRECT);
  assign ch2_edge = cap_en & (chan_cfg.ch2_falling ? (ch2_prev & ~ch2_in)
                                : (~ch2_prev & ch2_in));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_prev <= 1'b0;
    end else begin
      ch2_prev <= ch2_in;
    end
  end

  // no bus write path: only a capture changes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_capture_compare_value <= '0;
    end else if (ch2_edge) begin
      ch2_capture_compare_value <= counter;
    end
  end

  // flags clear on a written 0; a capture read also clears the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= TIMER_STATUS_RESET;
    end else begin
      status.update_flag <= sticky(status.update_flag, upd_event,
                                   wr_status & ~pwdata[0]);
      status.ch2_capture_flag <= sticky(status.ch2_capture_flag, ch2_edge,
        (wr_status & ~pwdata[1]) | rd_capture);
      status.ch2_overcapture_flag <= sticky(status.ch2_overcapture_flag,
        ch2_edge & status.ch2_capture_flag,
        wr_status & ~pwdata[2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_dma_req <= 1'b0;
    end else begin
      ch2_dma_req <= ch2_edge & chan_cfg.ch2_dma_enable;
    end
  end

  // ***************************************************************
  // channel 1 pwm output
  // ***************************************************************
  logic below;
  logic oc_ref;
  assign below = counter < channel_compare_value;
  always_comb begin
    unique case (chan_cfg.ch1_mode)
      OC_PWM_MODE_FIRST: oc_ref = below;
      OC_PWM_MODE_SECOND: oc_ref = ~below;
      default: oc_ref = 1'b0;
    endcase
  end

  // output lags the counter by one clock so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch1_out <= 1'b0;
    end else begin
      ch1_out <= chan_cfg.ch1_out_enable
                 & (oc_ref ^ chan_cfg.ch1_invert);
    end
  end

  // ***************************************************************
  // apb read and handshake, one wait state
  // ***************************************************************
  logic [31:0] next_rdata;
  logic next_err;
  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    unique case ({paddr[11:2], 2'b00})
      OFF_MAIN_CONTROL: next_rdata[2:0] = ctrl;
      OFF_TIMER_STATUS: next_rdata[2:0] = status;
      OFF_EVENT_GENERATE: next_rdata = 32'h00000000;
      OFF_EXT_CLOCK: next_rdata[3:0] = ext_cfg;
      OFF_CHANNEL_CONFIG: next_rdata[9:0] = chan_cfg;
      OFF_COUNTER_VALUE: next_rdata[CNT_W-1:0] = counter;
      OFF_PRESCALER_VALUE: next_rdata[PSC_W-1:0] = prescaler_value;
      OFF_AUTO_RELOAD: next_rdata[CNT_W-1:0] = auto_reload_value;
      OFF_COMPARE_VALUE: next_rdata[CNT_W-1:0] = channel_compare_value;
      OFF_CH2_CAPTURE: begin
        next_rdata[CNT_W-1:0] = ch2_capture_compare_value;
        next_err = pwrite;
      end
      OFF_REPETITION: next_rdata[REP_W-1:0] = repetition_count;
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_update;
    overflow && ctrl.single_shot_bit && !ctrl.update_suppress
      && rep_cnt == '0 && !wr_main;
  endsequence

  sequence s_pwm_mode_second_plain;
    chan_cfg.ch1_mode == OC_PWM_MODE_SECOND && chan_cfg.ch1_out_enable
      && !chan_cfg.ch1_invert;
  endsequence

  a_capture_takes_count: assert property (
    ch2_edge |=> ch2_capture_compare_value == $past(counter))
    else $error("capture value differs from counter");
  a_capture_flag_sets: assert property (
    ch2_edge |=> status.ch2_capture_flag)
    else $error("capture flag not set");
  a_dma_follows_capture: assert property (
    ch2_edge && chan_cfg.ch2_dma_enable |=> ch2_dma_req ##1 !ch2_dma_req
      || ch2_edge)
    else $error("dma request missing or too long");
  a_overcapture_sets: assert property (
    ch2_edge && status.ch2_capture_flag |=> status.ch2_overcapture_flag)
    else $error("overcapture flag not set");
  a_rising_edge_only: assert property (
    ch2_edge && !chan_cfg.ch2_falling |-> ch2_in && !ch2_prev)
    else $error("capture on wrong edge");
  a_select_gates_path: assert property (
    chan_cfg.ch2_input_select != CH2_SELECT_DIRECT |-> !ch2_edge)
    else $error("capture with input not routed");
  a_counter_counts_up: assert property (
    cnt_tick && !overflow && !ug && !wr |=> counter == $past(counter) + 1)
    else $error("counter did not step up");
  a_ext_clock_holds: assert property (
    ext_cfg.ext_clock_mode2_enable && !etr_tick && !wr
      |=> $stable(counter))
    else $error("counter moved without trigger edge");
  a_etr_div_four: assert property (
    ext_cfg.ext_clock_mode2_enable && ext_cfg.etr_prescale == ETR_DIV4
      && etr_tick |-> etr_div_cnt == 3'h3)
    else $error("trigger prescale not four");
  a_update_reload: assert property (
    ug |=> psc_active == $past(prescaler_value) && counter == '0
      && rep_cnt == $past(repetition_count))
    else $error("update generate did not reload");
  a_single_shot_stop: assert property (
    s_stop_update |=> !ctrl.counter_run_enable && counter == '0
      ##1 counter == '0 || wr)
    else $error("single shot did not stop at zero");
  a_suppress_keeps_run: assert property (
    overflow && ctrl.update_suppress && !wr_main
      |=> ctrl.counter_run_enable)
    else $error("suppressed update stopped the counter");
  a_repeat_decrements: assert property (
    rep_masked && !ug && !wr_main |=> rep_cnt == $past(rep_cnt) - 1
      && ctrl.counter_run_enable)
    else $error("repetition not decremented or run lost");
  a_pwm_mode_second_delay_pulse: assert property (
    s_pwm_mode_second_plain |=> ch1_out == ($past(counter) >= $past(
      channel_compare_value)))
    else $error("pwm second mode waveform wrong");
  a_capture_readonly: assert property (
    !ch2_edge |=> $stable(ch2_capture_compare_value))
    else $error("capture value changed without capture");

endmodule

//--- verification/sig_source.sv
`timescale 1ns/1ps
// ***************************************************************
// measured signal and external reference clock source
// ***************************************************************
module sig_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the bench
  input wire logic ch2_run,
  input wire logic [3:0] ch2_half,
  input wire logic [7:0] ext_target,
  // lines into the timer
  output logic ch2_in,
  output logic external_trigger_input
);
  logic [3:0] ph;
  logic [7:0] ext_done;
  logic ext_ph;

  // steady square wave, idle low; period far below a counter wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 4'h0;
      ch2_in <= 1'b0;
    end else if (!ch2_run) begin
      ph <= 4'h0;
      ch2_in <= 1'b0;
    end else if (ph == ch2_half - 4'h1) begin
      ph <= 4'h0;
      ch2_in <= ~ch2_in;
    end else begin
      ph <= ph + 4'h1;
    end
  end

  // bursts of edges, 4 pclk each; after divide-by-4 well under a third
  // of the kernel clock; stands low between bursts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_done <= 8'h00;
      ext_ph <= 1'b0;
      external_trigger_input <= 1'b0;
    end else if (ext_done != ext_target || external_trigger_input) begin
      ext_ph <= ~ext_ph;
      if (ext_ph) begin
        external_trigger_input <= ~external_trigger_input;
        if (!external_trigger_input) begin
          ext_done <= ext_done + 8'h01;
        end
      end
    end
  end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  import timer_capture_pkg::*;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v1, cmp, lfsr, mm;
  logic ch2_in, ext_in, ch1_out, ch2_dma_req, ch2_run, last1;
  logic [3:0] ch2_half;
  logic [7:0] ext_target;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  int n_fail, checks_done, cyc, rises, highs, dmas, r0, h0;
  logic [11:0] offs [5] = '{OFF_MAIN_CONTROL, OFF_TIMER_STATUS,
    OFF_EXT_CLOCK, OFF_CHANNEL_CONFIG, OFF_AUTO_RELOAD};
  logic [31:0] rstv [5] = '{32'h0, 32'h0, 32'h0, 32'h0, AUTO_RELOAD_RESET};
  logic [31:0] cfg [3] = '{32'h2E0, 32'h2C0, 32'h3E0};
  logic lvl [3] = '{1'b0, 1'b1, 1'b1};

  timer_capture_onepulse i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch2_in(ch2_in), .external_trigger_input(ext_in),
    .ch1_out(ch1_out), .ch2_dma_req(ch2_dma_req));
  sig_source i_src (.pclk(pclk), .presetn(presetn), .ch2_run(ch2_run),
    .ch2_half(ch2_half), .ext_target(ext_target), .ch2_in(ch2_in),
    .external_trigger_input(ext_in));

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // apb master; note first, the monitor compares at pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic err,
                     input logic [31:0] want, input logic [31:0] m);
    exp_q.push_back({err, want & m});
    msk_q.push_back(m);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] w,
                     input logic [31:0] m);
    apb(1'b0, a, 32'h0, 1'b0, w, m);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_dma;
    int k;
    k = 0;
    while (ch2_dma_req !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    check({32'h0, k < 400}, 33'h1);
  endtask

  // ***************************************************************
  // clock, monitors, timeout
  // ***************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      mm = msk_q.pop_front();
      check({pslverr, prdata & mm}, exp_q.pop_front());
    end
  end

  // counts, and fails the run at cycle 20000; otherwise the run is judged by the main sequence
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    last1 <= ch1_out;
    if (ch1_out === 1'b1) highs <= highs + 1;
    if (ch1_out === 1'b1 && last1 === 1'b0) rises <= rises + 1;
    if (ch2_dma_req === 1'b1) dmas <= dmas + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {psel, penable, pwrite, presetn, ch2_run, last1} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ch2_half = 4'h3;
    ext_target = 8'h00;
    lfsr = 32'hCF53;
    {n_fail, checks_done, cyc, rises, highs, dmas} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rdc(offs[i], rstv[i], 32'hFFFFFFFF);
    apb(1'b0, 12'h02C, 32'h0, 1'b1, 32'h0, 32'hFFFFFFFF);
    apb(1'b1, OFF_CH2_CAPTURE, 32'h5A, 1'b1, 32'h0, 32'h0);
    rdc(OFF_CH2_CAPTURE, 32'h0, 32'hFFFFFFFF);
    wr(OFF_COUNTER_VALUE, 32'hFFFFFFF0);
    rdc(OFF_COUNTER_VALUE, 32'hFFFFFFF0, 32'hFFFFFFFF);
    wr(OFF_EVENT_GENERATE, 32'h1);
    rdc(OFF_COUNTER_VALUE, 32'h0, 32'hFFFFFFFF);
    // capture: rising edge, direct select, dma on
    lfsr = next_rand(lfsr);
    ch2_half <= 4'h3 + {2'b00, lfsr[1:0]};
    wr(OFF_CHANNEL_CONFIG, 32'h19);
    wr(OFF_MAIN_CONTROL, 32'h1);
    ch2_run <= 1'b1;
    wait_dma();
    rdc(OFF_CH2_CAPTURE, 32'h0, 32'h0);
    v1 = rd;
    wait_dma();
    rdc(OFF_CH2_CAPTURE, 32'h0, 32'h0);
    check({1'b0, rd - v1}, {28'h0, ch2_half, 1'b0});
    tick(32);
    rdc(OFF_TIMER_STATUS, 32'h6, 32'h6);
    wr(OFF_TIMER_STATUS, 32'h0);
    wr(OFF_CHANNEL_CONFIG, 32'h1A);
    r0 = dmas;
    tick(30);
    check({1'b0, 32'(dmas - r0)}, 33'h0);
    ch2_run <= 1'b0;
    // counter from the trigger input through divide-by-4
    wr(OFF_MAIN_CONTROL, 32'h0);
    wr(OFF_COUNTER_VALUE, 32'h0);
    wr(OFF_EXT_CLOCK, 32'h5);
    wr(OFF_MAIN_CONTROL, 32'h1);
    ext_target <= 8'd16;
    tick(84);
    rdc(OFF_COUNTER_VALUE, 32'h4, 32'hFFFFFFFF);
    wr(OFF_MAIN_CONTROL, 32'h0);
    wr(OFF_EXT_CLOCK, 32'h0);
    // single shot, three pulses, random compare
    lfsr = next_rand(lfsr);
    cmp = {29'h0, lfsr[2:0]} + 32'h1;
    wr(OFF_AUTO_RELOAD, 32'h9);
    wr(OFF_COMPARE_VALUE, cmp);
    wr(OFF_REPETITION, 32'h2);
    wr(OFF_CHANNEL_CONFIG, 32'h2E0);
    wr(OFF_EVENT_GENERATE, 32'h1);
    // let the stale output level from before the update drain first
    tick(2);
    r0 = rises;
    h0 = highs;
    wr(OFF_MAIN_CONTROL, 32'h5);
    tick(60);
    check({1'b0, 32'(rises - r0)}, 33'h3);
    check({1'b0, 32'(highs - h0)}, {1'b0, 32'h1E - 32'h3 * cmp});
    rdc(OFF_MAIN_CONTROL, 32'h4, 32'hFFFFFFFF);
    rdc(OFF_COUNTER_VALUE, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CHANNEL_CONFIG, cfg[i]);
      tick(2);
      check({32'h0, ch1_out}, {32'h0, lvl[i]});
    end
    // suppressed updates keep the counter and output running
    wr(OFF_CHANNEL_CONFIG, 32'h2E0);
    r0 = rises;
    wr(OFF_MAIN_CONTROL, 32'h7);
    tick(60);
    check({32'h0, (rises - r0) > 3}, 33'h1);
    rdc(OFF_MAIN_CONTROL, 32'h7, 32'hFFFFFFFF);
    wr(OFF_MAIN_CONTROL, 32'h0);
    end_sim();
  end
endmodule
